// >>> verilog/ppc_port_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Per-pin weak pull-up from enable field
// - Pull-up off while pin is output
// - Global disable bit set after power-on
// - Change detect only on pins 7..4
// - Change enables cleared by reset
// - Compare pins with last-read latch
// - OR of mismatches sets change flag
// - Enabled flag raises wake request
// - Port read or write refreshes latch
// - Mismatch keeps re-setting the flag
// - Latch survives master clear, brown-out
// - Change during read may be missed
// - Pins 7, 6 carry programming data/clock
// - Pin 0 doubles as edge interrupt
// - LCD unit drives its routed pins
// - Segment enables reset by power/brown-out
// - Unimplemented locations read as zero
// - Direction one tristates, zero drives latch
// - Read gives pins, write sets latch
// - Pull-ups obey the global disable
module ppc_port_ctrl
   import ppc_pkg::*;
#(
   parameter int PADDR_W = 12
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               por_n,
   input  wire logic               bor_n,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output var  logic [31:0]        prdata,
   output var  logic               pready,
   output var  logic               pslverr,
   input  wire logic [7:0]         p1_pin_in,
   output var  logic [7:0]         p1_pin_out,
   output var  logic [7:0]         p1_pin_oe,
   input  wire logic [7:0]         p2_pin_in,
   output var  logic [7:0]         p2_pin_out,
   output var  logic [7:0]         p2_pin_oe,
   output var  logic [7:0]         p2_pullup_on,
   input  wire logic [7:0]         lcd_seg_level,
   input  wire logic [7:0]         lcd_seg_drive,
   input  wire logic               lcd_write_err,
   input  wire logic [1:0]         cmp_out,
   input  wire logic               prog_mode,
   input  wire logic               prog_data_out,
   input  wire logic               prog_data_oe,
   output var  logic               prog_data_in,
   output var  logic               prog_clk_in,
   output var  logic               ext_edge_pulse,
   output var  logic               port_change_flag,
   output var  logic               wake_req,
   output var  logic [7:0]         option_cfg,
   output var  logic [7:0]         analog_sel,
   output var  logic [7:0]         cmp_cfg,
   output var  logic [7:0]         lcd_cfg,
   output var  logic [15:0]        lcd_seg_enable
);

   // ----------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------
   if (PADDR_W < IDX_W + 2) begin : g_bad_addr
      $error("PADDR_W too narrow for the register map");
   end

   // ----------------------------------------------------------
   // Reset domains
   // ----------------------------------------------------------
   // Combined async resets; all sources are clean reset nets
   logic rst_all_n;
   logic rst_pwr_n;

   assign rst_all_n = presetn & por_n & bor_n;
   assign rst_pwr_n = por_n & bor_n;

   // ----------------------------------------------------------
   // State
   // ----------------------------------------------------------
   ppc_state_s state_reg;
   ppc_state_s state_next;
   ppc_lcdse_s lcdse_reg;
   ppc_lcdse_s lcdse_next;

   // ----------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------
   logic [7:0] p1_sync;
   logic [7:0] p2_sync;

   ppc_sync #(
      .W (8)
   ) u_sync_p1 (
      .clk   (pclk),
      .rst_n (rst_all_n),
      .d     (p1_pin_in),
      .q     (p1_sync)
   );

   ppc_sync #(
      .W (8)
   ) u_sync_p2 (
      .clk   (pclk),
      .rst_n (rst_all_n),
      .d     (p2_pin_in),
      .q     (p2_sync)
   );

   // ----------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------
   logic [IDX_W-1:0] idx;
   logic             setup;
   logic             access;
   logic             wr;
   logic             lane0;
   logic [7:0]       wdata;
   logic             mapped;
   logic [7:0]       rd_val;
   logic             p2_touch;
   logic             mismatch;
   logic             edge_evt;

   assign idx    = paddr[IDX_W+1:2];
   assign setup  = psel && !penable;
   assign access = psel && penable;
   assign wr     = access && pwrite && lane0 && !state_reg.pslverr;
   assign lane0  = pstrb[0];
   assign wdata  = pwdata[7:0];

   // First-port analog inputs read as zero
   logic [7:0] p1_read;
   assign p1_read = p1_sync & ~{2'b00, state_reg.analog_pin_select[4], 1'b0,
                                state_reg.analog_pin_select[3:0]};

   always_comb begin
      mapped = 1'b1;
      rd_val = 8'h00;
      unique case (idx)
         IDX_P1_DATA:     rd_val = p1_read;
         IDX_P2_DATA,
         IDX_P2_DATA_ALT: rd_val = p2_sync;
         IDX_INTCTL:      rd_val = state_reg.intctl;
         IDX_OPTION,
         IDX_OPTION_ALT:  rd_val = state_reg.option;
         IDX_P1_DIR:      rd_val = state_reg.p1_dir;
         IDX_P2_DIR,
         IDX_P2_DIR_ALT:  rd_val = state_reg.p2_dir;
         IDX_ANALOG_PIN_SELECT:       rd_val = state_reg.analog_pin_select;
         IDX_WPU:         rd_val = state_reg.wpu;
         IDX_IOC:         rd_val = state_reg.ioc & IOC_MASK;
         IDX_CMCON:       rd_val = {cmp_out, state_reg.cmcon[5:0]};
         IDX_LCD_CONTROL:      rd_val = state_reg.lcd_control;
         IDX_LCD_SEGMENT_ENABLE_LOW:      rd_val = lcdse_reg.se0;
         IDX_LCD_SEGMENT_ENABLE_HIGH:      rd_val = lcdse_reg.se1;
         default: begin
            mapped = 1'b0;
            rd_val = 8'h00;
         end
      endcase
      if (paddr[1:0] != 2'b00) begin
         mapped = 1'b0;
      end
   end

   // Any access phase to the second port data word counts unless it is refused with pslverr
   assign p2_touch = access && !state_reg.pslverr &&
                     ((idx == IDX_P2_DATA) || (idx == IDX_P2_DATA_ALT));

   // ----------------------------------------------------------
   // Change detection
   // ----------------------------------------------------------
   ppc_change_det u_chg (
      .clk      (pclk),
      .por_n    (por_n),
      .refresh  (p2_touch),
      .pins     (p2_sync),
      .enable   (state_reg.ioc),
      .mismatch (mismatch)
   );

   // Edge on pin 0, polarity from the option register
   assign edge_evt = state_reg.option[OPT_EDGE_RISE] ?
                     (p2_sync[EXT_IRQ_PIN] && !state_reg.pin0_prev) :
                     (!p2_sync[EXT_IRQ_PIN] && state_reg.pin0_prev);

   // ----------------------------------------------------------
   // Next state
   // ----------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      lcdse_next = lcdse_reg;
      state_next.pin0_prev = p2_sync[EXT_IRQ_PIN];
      if (setup) begin
         state_next.prdata  = mapped ? rd_val : 8'h00;
         state_next.pslverr = !mapped;
      end
      if (wr) begin
         unique case (idx)
            IDX_P1_DATA:     state_next.p1_latch = wdata;
            IDX_P2_DATA,
            IDX_P2_DATA_ALT: state_next.p2_latch = wdata;
            IDX_INTCTL:      state_next.intctl = wdata & INTCTL_WMASK;
            IDX_OPTION,
            IDX_OPTION_ALT:  state_next.option = wdata;
            IDX_P1_DIR:      state_next.p1_dir = wdata;
            IDX_P2_DIR,
            IDX_P2_DIR_ALT:  state_next.p2_dir = wdata;
            IDX_ANALOG_PIN_SELECT:       state_next.analog_pin_select = wdata;
            IDX_WPU:         state_next.wpu = wdata;
            IDX_IOC:         state_next.ioc = wdata & IOC_MASK;
            IDX_CMCON:       state_next.cmcon = wdata & CMCON_WMASK;
            IDX_LCD_CONTROL:      state_next.lcd_control = wdata;
            IDX_LCD_SEGMENT_ENABLE_LOW:      lcdse_next.se0 = wdata;
            IDX_LCD_SEGMENT_ENABLE_HIGH:      lcdse_next.se1 = wdata;
            default:         state_next.intctl = state_reg.intctl;
         endcase
      end
      // Hardware set wins over a software clear in the same cycle
      if (mismatch) begin
         state_next.intctl[INT_CHG_FLAG] = 1'b1;
      end
      if (edge_evt) begin
         state_next.intctl[INT_EDGE_FLAG] = 1'b1;
      end
      state_next.lcd_control[LCD_WERR_BIT] = lcd_write_err;
   end

   // ----------------------------------------------------------
   // Registers
   // ----------------------------------------------------------
   always_ff @(posedge pclk or negedge rst_all_n) begin
      if (!rst_all_n) begin
         state_reg          <= '0;
         state_reg.p1_latch <= RST_PORT;
         state_reg.p1_dir   <= RST_DIR;
         state_reg.option   <= RST_OPTION;
         state_reg.analog_pin_select    <= RST_ANALOG_PIN_SELECT;
         state_reg.cmcon    <= RST_CMCON;
         state_reg.lcd_control   <= RST_LCD_CONTROL;
         state_reg.p2_latch <= RST_PORT;
         state_reg.p2_dir   <= RST_DIR;
         state_reg.wpu      <= RST_WPU;
         state_reg.ioc      <= RST_IOC;
         state_reg.intctl   <= RST_INTCTL;
      end else begin
         state_reg <= state_next;
      end
   end

   // Segment enables ignore master clear
   always_ff @(posedge pclk or negedge rst_pwr_n) begin
      if (!rst_pwr_n) begin
         lcdse_reg.se0 <= RST_LCDSE;
         lcdse_reg.se1 <= RST_LCDSE;
      end else begin
         lcdse_reg <= lcdse_next;
      end
   end

   // ----------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------
   ppc_drive_s p2_drv;
   logic       lcd_on;

   assign lcd_on = state_reg.lcd_control[LCD_EN_BIT];

   for (genvar i = 0; i < 8; i++) begin : g_pin
      logic lcd_pin;
      logic prog_pin;

      assign lcd_pin  = lcd_on && lcdse_reg.se0[i];
      assign prog_pin = prog_mode &&
                        ((i == PROG_DATA_PIN) || (i == PROG_CLK_PIN));

      always_comb begin
         if (prog_pin) begin
            p2_drv.out[i] = (i == PROG_DATA_PIN) ? prog_data_out : 1'b0;
            p2_drv.oe[i]  = (i == PROG_DATA_PIN) ? prog_data_oe : 1'b0;
         end else if (lcd_pin) begin
            p2_drv.out[i] = lcd_seg_level[i];
            p2_drv.oe[i]  = lcd_seg_drive[i];
         end else begin
            p2_drv.out[i] = state_reg.p2_latch[i];
            p2_drv.oe[i]  = !state_reg.p2_dir[i];
         end
      end

      // Pull-up only on a GPIO input with global permission
      assign p2_pullup_on[i] = state_reg.wpu[i] &&
                               !state_reg.option[OPT_PU_DIS] &&
                               state_reg.p2_dir[i] &&
                               !lcd_pin && !prog_pin;

      assign p1_pin_out[i] = state_reg.p1_latch[i];
      assign p1_pin_oe[i]  = !state_reg.p1_dir[i];
   end

   assign p2_pin_out = p2_drv.out;
   assign p2_pin_oe  = p2_drv.oe;

   // ----------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------
   assign prdata         = {24'h0000_00, state_reg.prdata};
   assign pready         = 1'b1;
   assign pslverr        = access && state_reg.pslverr;
   assign prog_data_in   = p2_sync[PROG_DATA_PIN];
   assign prog_clk_in    = p2_sync[PROG_CLK_PIN];
   assign ext_edge_pulse = edge_evt;
   assign port_change_flag = state_reg.intctl[INT_CHG_FLAG];
   // Level request so a sleeping core sees it without a clock edge
   assign wake_req = (state_reg.intctl[INT_CHG_FLAG] &&
                      state_reg.intctl[INT_CHG_EN]) ||
                     (state_reg.intctl[INT_EDGE_FLAG] &&
                      state_reg.intctl[INT_EDGE_EN]);
   assign option_cfg     = state_reg.option;
   assign analog_sel     = state_reg.analog_pin_select;
   assign cmp_cfg        = state_reg.cmcon;
   assign lcd_cfg        = state_reg.lcd_control;
   assign lcd_seg_enable = {lcdse_reg.se1, lcdse_reg.se0};

endmodule : ppc_port_ctrl
`default_nettype wire

// >>> verilog/ppc_pkg.sv
package ppc_pkg;

   // -------------------------------------------------------------
   // Register indexes (byte address is four times the index)
   // -------------------------------------------------------------
   localparam int         IDX_W           = 9;
   localparam logic [8:0] IDX_P1_DATA     = 9'h005;
   localparam logic [8:0] IDX_P2_DATA     = 9'h006;
   localparam logic [8:0] IDX_P2_DATA_ALT = 9'h106;
   localparam logic [8:0] IDX_INTCTL      = 9'h00b;
   localparam logic [8:0] IDX_OPTION      = 9'h081;
   localparam logic [8:0] IDX_OPTION_ALT  = 9'h181;
   localparam logic [8:0] IDX_P1_DIR      = 9'h085;
   localparam logic [8:0] IDX_P2_DIR      = 9'h086;
   localparam logic [8:0] IDX_P2_DIR_ALT  = 9'h186;
   localparam logic [8:0] IDX_ANALOG_PIN_SELECT       = 9'h091;
   localparam logic [8:0] IDX_WPU         = 9'h095;
   localparam logic [8:0] IDX_IOC         = 9'h096;
   localparam logic [8:0] IDX_CMCON       = 9'h09c;
   localparam logic [8:0] IDX_LCD_CONTROL      = 9'h107;
   localparam logic [8:0] IDX_LCD_SEGMENT_ENABLE_LOW      = 9'h11c;
   localparam logic [8:0] IDX_LCD_SEGMENT_ENABLE_HIGH      = 9'h11d;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [7:0] RST_PORT   = 8'h00;
   localparam logic [7:0] RST_DIR    = 8'hff;
   localparam logic [7:0] RST_OPTION = 8'hff;
   localparam logic [7:0] RST_ANALOG_PIN_SELECT  = 8'hff;
   localparam logic [7:0] RST_CMCON  = 8'h00;
   localparam logic [7:0] RST_LCD_CONTROL = 8'h13;
   localparam logic [7:0] RST_LCDSE  = 8'h00;
   localparam logic [7:0] RST_WPU    = 8'hff;
   localparam logic [7:0] RST_IOC    = 8'h00;
   localparam logic [7:0] RST_INTCTL = 8'h00;

   // -------------------------------------------------------------
   // Field positions and masks
   // -------------------------------------------------------------
   localparam int         OPT_PU_DIS    = 7;
   localparam int         OPT_EDGE_RISE = 6;
   localparam int         INT_CHG_FLAG  = 0;
   localparam int         INT_EDGE_FLAG = 1;
   localparam int         INT_CHG_EN    = 3;
   localparam int         INT_EDGE_EN   = 4;
   localparam logic [7:0] INTCTL_WMASK  = 8'h1b;
   localparam int         LCD_EN_BIT    = 7;
   localparam int         LCD_WERR_BIT  = 5;
   localparam logic [7:0] CMCON_WMASK   = 8'h3f;
   localparam logic [7:0] IOC_MASK      = 8'hf0;
   localparam int         PROG_DATA_PIN = 7;
   localparam int         PROG_CLK_PIN  = 6;
   localparam int         EXT_IRQ_PIN   = 0;
   localparam int         SYNC_STAGES   = 2;

   // -------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } ppc_drive_s;

   typedef struct packed {
      logic [7:0] p1_latch;
      logic [7:0] p1_dir;
      logic [7:0] option;
      logic [7:0] analog_pin_select;
      logic [7:0] cmcon;
      logic [7:0] lcd_control;
      logic [7:0] p2_latch;
      logic [7:0] p2_dir;
      logic [7:0] wpu;
      logic [7:0] ioc;
      logic [7:0] intctl;
      logic       pin0_prev;
      logic [7:0] prdata;
      logic       pslverr;
   } ppc_state_s;

   typedef struct packed {
      logic [7:0] se0;
      logic [7:0] se1;
   } ppc_lcdse_s;

endpackage : ppc_pkg

// >>> verilog/ppc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_sync
   import ppc_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   // First stage feeds the second only
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : ppc_sync
`default_nettype wire

// >>> verilog/ppc_change_det.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_change_det
   import ppc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       por_n,
   input  wire logic       refresh,
   input  wire logic [7:0] pins,
   input  wire logic [7:0] enable,
   output var  logic       mismatch
);

   // Only power-on clears it; master clear and brown-out leave it
   logic [7:0] last_reg;
   logic [7:0] last_next;

   always_comb begin
      last_next = last_reg;
      if (refresh) begin
         last_next = pins & IOC_MASK;
      end
   end

   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         last_reg <= RST_PORT;
      end else begin
         last_reg <= last_next;
      end
   end

   // Refresh wins this cycle; a pin moving now is latched and never flagged
   assign mismatch = !refresh &&
                     (|((pins ^ last_reg) & enable & IOC_MASK));

endmodule : ppc_change_det
`default_nettype wire

// >>> test/ppc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_model (
   input  wire logic       clk,
   input  wire logic [7:0] oe,
   input  wire logic [7:0] out,
   input  wire logic [7:0] pull,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output var  logic [7:0] pin
);
   logic tog_reg = 1'b0;
   // Floating pins toggle so a stale level never fakes a match
   always_ff @(posedge clk) tog_reg <= ~tog_reg;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pull[i] ? 1'b1 : tog_reg;
      end
   end
endmodule : ppc_pin_model
`default_nettype wire

// >>> test/ppc_port_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_port_ctrl_sva
   import ppc_pkg::*;
#(
   parameter int PADDR_W = 12
) (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               por_n,
   input wire logic               bor_n,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [3:0]         pstrb,
   input wire logic [31:0]        prdata,
   input wire logic               pslverr,
   input wire logic [7:0]         p1_pin_out,
   input wire logic [7:0]         p1_pin_oe,
   input wire logic [7:0]         p2_pin_oe,
   input wire logic [7:0]         p2_pullup_on,
   input wire logic               prog_mode,
   input wire logic               ext_edge_pulse,
   input wire logic [7:0]         option_cfg,
   input wire logic [7:0]         lcd_cfg,
   input wire logic [15:0]        lcd_seg_enable
);
   wire logic rst_ok;
   assign rst_ok = presetn & por_n & bor_n;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!rst_ok);

   sequence s_wr(logic [8:0] idx);
      psel && penable && pwrite && pstrb[0] && paddr[1:0] == 2'b00 &&
      paddr[PADDR_W-1:2] == (PADDR_W-2)'(idx);
   endsequence
   sequence s_bad;
      psel && !penable && paddr[1:0] != 2'b00 ##1 psel && penable;
   endsequence

   chk_opt_copy: assert property (s_wr(IDX_OPTION) |=> option_cfg == $past(pwdata[7:0]))
      else $error("option copy wrong");
   chk_dir_commit: assert property (s_wr(IDX_P1_DIR) |=> p1_pin_oe == ~$past(pwdata[7:0]))
      else $error("direction write wrong");
   chk_latch_commit: assert property (s_wr(IDX_P1_DATA) |=> p1_pin_out == $past(pwdata[7:0]))
      else $error("latch write wrong");
   chk_port_hold: assert property (!(psel && penable && pwrite) |=> $stable(p1_pin_oe) && $stable(p1_pin_out))
      else $error("port changed without write");
   chk_seg_copy: assert property (s_wr(IDX_LCD_SEGMENT_ENABLE_LOW) |=> lcd_seg_enable[7:0] == $past(pwdata[7:0]))
      else $error("segment enable wrong");
   chk_pu_global: assert property (option_cfg[OPT_PU_DIS] |-> p2_pullup_on == 8'h00)
      else $error("pull-up despite global disable");
   chk_pu_output: assert property (!prog_mode && !lcd_cfg[LCD_EN_BIT] |-> (p2_pullup_on & p2_pin_oe) == 8'h00)
      else $error("pull-up on output pin");
   chk_bad_zero: assert property (s_bad |-> pslverr && prdata == '0)
      else $error("misaligned access not refused");
   chk_upper_zero: assert property (prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   chk_edge_pulse: assert property (ext_edge_pulse |=> !ext_edge_pulse)
      else $error("edge pulse too long");
endmodule : ppc_port_ctrl_sva

bind ppc_port_ctrl ppc_port_ctrl_sva #(.PADDR_W(PADDR_W)) ppc_port_ctrl_sva_i (
   .pclk, .presetn, .por_n, .bor_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pslverr, .p1_pin_out, .p1_pin_oe, .p2_pin_oe, .p2_pullup_on, .prog_mode,
   .ext_edge_pulse, .option_cfg, .lcd_cfg, .lcd_seg_enable
);
`default_nettype wire

// >>> test/port_pullup_change_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_pullup_change_irq_tb;
   import ppc_pkg::*;
   `define CHK(n, x, g) begin checks_done++; if ((g) !== (x)) begin errors++; \
      $display("CHECK FAILED %s expected %h seen %h", n, x, g); end end
   typedef struct packed {
      logic [8:0] idx;
      logic [7:0] rv;
      logic [7:0] wd;
      logic [7:0] rb;
   } ppc_row_s;
   int errors = 0;
   int checks_done = 0;
   logic pclk = 0, presetn = 0, por_n = 0, bor_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic prog_mode = 0, prog_data_out = 0, prog_data_oe = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   // Pin 0 held low at first so a floating pin raises no edge flag
   logic [7:0] p1_en = '0, p1_val = '0, p2_en = 8'h01, p2_val = '0;
   logic [7:0] lcd_seg_level = '0, lcd_seg_drive = '0;
   logic [31:0] prdata;
   logic pready, pslverr, prog_data_in, prog_clk_in, ext_edge_pulse, port_change_flag, wake_req;
   logic [7:0] p1_pin, p1_pin_out, p1_pin_oe, p2_pin, p2_pin_out, p2_pin_oe, p2_pullup_on;
   logic [7:0] option_cfg, lcd_cfg;
   logic [15:0] lcd_seg_enable;
   ppc_row_s rows [11] = '{
      '{IDX_INTCTL, 8'h00, 8'h08, 8'h08}, '{IDX_OPTION, 8'hff, 8'h7f, 8'h7f},
      '{IDX_P1_DIR, 8'hff, 8'h00, 8'h00}, '{IDX_ANALOG_PIN_SELECT, 8'hff, 8'h00, 8'h00},
      '{IDX_CMCON, 8'h00, 8'h07, 8'h07}, '{IDX_LCD_CONTROL, 8'h13, 8'h13, 8'h13},
      '{IDX_LCD_SEGMENT_ENABLE_LOW, 8'h00, 8'h5a, 8'h5a}, '{IDX_LCD_SEGMENT_ENABLE_HIGH, 8'h00, 8'ha5, 8'ha5},
      '{IDX_WPU, 8'hff, 8'h3c, 8'h3c}, '{IDX_P2_DIR, 8'hff, 8'h0f, 8'h0f},
      '{IDX_IOC, 8'h00, 8'hff, 8'hf0}};

   ppc_port_ctrl ppc_port_ctrl_i (
      .pclk, .presetn, .por_n, .bor_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'h1), .prdata, .pready, .pslverr, .p1_pin_in(p1_pin), .p1_pin_out, .p1_pin_oe,
      .p2_pin_in(p2_pin), .p2_pin_out, .p2_pin_oe, .p2_pullup_on, .lcd_seg_level,
      .lcd_seg_drive, .lcd_write_err(1'b0), .cmp_out(2'b00), .prog_mode, .prog_data_out,
      .prog_data_oe, .prog_data_in, .prog_clk_in, .ext_edge_pulse, .port_change_flag,
      .wake_req, .option_cfg, .analog_sel(), .cmp_cfg(), .lcd_cfg, .lcd_seg_enable);
   ppc_pin_model ppc_pin_model_i (.clk(pclk), .oe(p2_pin_oe), .out(p2_pin_out),
      .pull(p2_pullup_on), .ext_en(p2_en), .ext_val(p2_val), .pin(p2_pin));
   ppc_pin_model p1_ppc_pin_model_i (.clk(pclk), .oe(p1_pin_oe), .out(p1_pin_out),
      .pull(8'h00), .ext_en(p1_en), .ext_val(p1_val), .pin(p1_pin));

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic wr(input logic [8:0] i, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, {1'b0, i, 2'b00}, d, r, e);
   endtask : wr
   task automatic rd(input logic [8:0] i, input logic [7:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, {1'b0, i, 2'b00}, 8'h00, r, e);
      `CHK("rdata", {24'h00_0000, x}, r);
      `CHK("pslverr", 1'b0, e);
   endtask : rd
   task automatic fl(input logic x);
      repeat (5) @(negedge pclk);
      `CHK("change flag", x, port_change_flag);
      @(posedge pclk);
   endtask : fl
   // Reset kind: 0 master clear, 1 brown-out, 2 power-on
   task automatic rst(input int k);
      @(posedge pclk);
      if (k == 0) presetn <= 0; else if (k == 1) bor_n <= 0; else por_n <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1; bor_n <= 1; por_n <= 1;
      repeat (3) @(posedge pclk);
   endtask : rst
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial forever #10 pclk = ~pclk;
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      end_sim();
   end
   initial begin
      logic [31:0] r;
      logic e;
      int cnt;
      repeat (12) @(posedge pclk);
      presetn <= 1; por_n <= 1; bor_n <= 1;
      foreach (rows[k]) begin
         rd(rows[k].idx, rows[k].rv);
         wr(rows[k].idx, rows[k].wd);
         rd(rows[k].idx, rows[k].rb);
      end
      `CHK("pullups", 8'h0c, p2_pullup_on);
      wr(IDX_OPTION, 8'hff);
      @(negedge pclk);
      `CHK("pullups off", 8'h00, p2_pullup_on);
      apb(1'b0, 12'h3fc, 8'h00, r, e);
      `CHK("unmapped", 33'h1_0000_0000, {e, r});
      apb(1'b1, 12'h215, 8'h12, r, e);
      `CHK("misaligned oe", 9'h1ff, {e, p1_pin_oe});
      wr(IDX_P1_DATA, 8'ha5);
      @(negedge pclk);
      `CHK("p1 drive", 16'ha5ff, {p1_pin_out, p1_pin_oe});
      // Pin reads trail the pins by the two synchroniser stages
      repeat (2) @(posedge pclk);
      rd(IDX_P1_DATA, 8'ha5);
      wr(IDX_P1_DIR, 8'hff);
      p1_en <= 8'hff; p1_val <= 8'h3c;
      repeat (2) @(posedge pclk);
      rd(IDX_P1_DATA, 8'h3c);
      // Interrupt service order: refresh the port, then clear
      wr(IDX_P2_DIR, 8'hff);
      p2_en <= 8'hff; p2_val <= 8'h00;
      repeat (4) @(posedge pclk);
      rd(IDX_P2_DATA, 8'h00);
      wr(IDX_INTCTL, 8'h08);
      fl(1'b0);
      p2_val <= 8'h10;
      fl(1'b1);
      `CHK("wake", 1'b1, wake_req);
      wr(IDX_INTCTL, 8'h08);
      fl(1'b1);
      rd(IDX_P2_DATA_ALT, 8'h10);
      wr(IDX_INTCTL, 8'h08);
      fl(1'b0);
      p2_val <= 8'h14;
      fl(1'b0);
      rd(IDX_P2_DATA, 8'h14);
      // Last-read latch across the three reset kinds
      for (int k = 0; k < 3; k++) begin
         rst(k);
         `CHK("seg enable", k ? 16'h0000 : 16'ha55a, lcd_seg_enable);
         rd(IDX_IOC, 8'h00);
         wr(IDX_IOC, 8'hf0);
         fl(k == 2);
      end
      `CHK("wake masked", 1'b0, wake_req);
      rd(IDX_OPTION, 8'hff);
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         p2_val <= k ? 8'h14 : 8'h15;
         cnt = 0;
         repeat (6) begin
            @(negedge pclk);
            cnt += (ext_edge_pulse === 1'b1);
         end
         `CHK("edges", 1 - k, cnt);
      end
      @(posedge pclk);
      prog_mode <= 1; prog_data_oe <= 1; prog_data_out <= 1; p2_en <= 8'h7e; p2_val <= 8'h54;
      repeat (4) @(negedge pclk);
      `CHK("prog pins", 4'hf, {p2_pin_oe[7], p2_pin_out[7], prog_clk_in, prog_data_in});
      wr(IDX_LCD_CONTROL, 8'h93);
      wr(IDX_LCD_SEGMENT_ENABLE_LOW, 8'h01);
      prog_mode <= 0; lcd_seg_drive <= 8'hff; lcd_seg_level <= 8'h55;
      @(negedge pclk);
      `CHK("lcd pin", 2'b11, {p2_pin_oe[0], p2_pin_out[0]});
      end_sim();
   end
endmodule : port_pullup_change_irq_tb
`default_nettype wire
